// *** hw/rcp_defines.vh ***
`ifndef RCP_DEFINES_VH
`define RCP_DEFINES_VH

// Register offsets of the controller's own port
`define RCP_REG_CTRL 8'h00
`define RCP_REG_CFG_FREQ 8'h04
`define RCP_REG_CFG_CODES 8'h08
`define RCP_REG_STATUS 8'h0C
`define RCP_REG_RPL_FREQ 8'h10
`define RCP_REG_RPL_CODES 8'h14

// Control bits
`define RCP_CTRL_READ 0
`define RCP_CTRL_WRITE 1

// Status bits
`define RCP_ST_BUSY 0
`define RCP_ST_DONE 1
`define RCP_ST_TIMEOUT 2
`define RCP_ST_READY 3
`define RCP_ST_BAD_REPLY 4
`define RCP_ST_REFUSED 5

// Code register nibbles
`define RCP_F_RATE 3:0
`define RCP_F_POWER 7:4
`define RCP_F_BAUD 11:8
`define RCP_F_PARITY 15:12

// Factory defaults and frequency limits, frequency as six BCD digits of kHz
`define RCP_RST_FREQ 24'h434000
`define RCP_RST_CODES 16'h0393
`define RCP_FREQ_MIN 24'h418000
`define RCP_FREQ_MAX 24'h455000

// Characters
`define RCP_CH_SP 8'h20
`define RCP_CH_CR 8'h0D
`define RCP_CH_LF 8'h0A

// Timing
`define RCP_CLK_HZ 100000000
`define RCP_SETUP_BAUD 9600
`define RCP_POWERUP_MS 50
`define RCP_ENTRY_MS 1
`define RCP_REPLY_MS 200
`define RCP_APPLY_MS 10
`define RCP_RECONF_MS 100
`define RCP_CYC_PER_MS (`RCP_CLK_HZ / 1000)

`endif

// *** hw/rcp_host.v ***
// Operation
// - Drive select pin low, wait at least 1 ms, then send.
// - Setting traffic uses 9600 baud, eight bits, no parity.
// - One command per low period of the select pin.
// - Commands are ASCII; only read and write exist.
// - Write is W R then five space separated fields, ending CR LF.
// - Frequency is decimal kHz, valid 418000 to 455000.
// - Radio rate digit 1 to 4.
// - Power digit 0 to 9.
// - Host rate digit 0 to 6.
// - Parity digit 0 none, 1 even, 2 odd.
// - At most one party transmits on the half-duplex link.
`timescale 1ns/10ps
`include "rcp_defines.vh"

module rcp_host #(
    parameter POWERUP_CYC = `RCP_POWERUP_MS * `RCP_CYC_PER_MS,
    parameter ENTRY_CYC = `RCP_ENTRY_MS * `RCP_CYC_PER_MS,
    parameter REPLY_CYC = `RCP_REPLY_MS * `RCP_CYC_PER_MS,
    parameter APPLY_CYC = `RCP_APPLY_MS * `RCP_CYC_PER_MS,
    parameter RECONF_CYC = `RCP_RECONF_MS * `RCP_CYC_PER_MS,
    parameter BAUD_CYC = (`RCP_CLK_HZ + `RCP_SETUP_BAUD / 2) / `RCP_SETUP_BAUD
) (
    input wire clk,
    input wire rstn,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    output reg uart_tx,
    input wire uart_rx,
    output reg cfg_sel_n
);

localparam ST_IDLE = 3'd0;
localparam ST_ENTRY = 3'd1;
localparam ST_SEND = 3'd2;
localparam ST_WAIT = 3'd3;
localparam ST_APPLY = 3'd4;

////////////////////////////////////////////////////////////////////////
// Reset release
reg rst_s1;
reg rst_n;
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rst_s1 <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_n <= rst_s1;
    end
end

////////////////////////////////////////////////////////////////////////
// Command bytes
function [7:0] cmd_byte;
    input [4:0] i;
    input is_wr;
    input [23:0] f;
    input [15:0] c;
    begin
        if (!is_wr) begin
            case (i)
                5'd0: cmd_byte = 8'h52;
                5'd1: cmd_byte = 8'h44;
                5'd2: cmd_byte = `RCP_CH_CR;
                default: cmd_byte = `RCP_CH_LF;
            endcase
        end else begin
            case (i)
                5'd0: cmd_byte = 8'h57;
                5'd1: cmd_byte = 8'h52;
                5'd3: cmd_byte = {4'h3, f[23:20]};
                5'd4: cmd_byte = {4'h3, f[19:16]};
                5'd5: cmd_byte = {4'h3, f[15:12]};
                5'd6: cmd_byte = {4'h3, f[11:8]};
                5'd7: cmd_byte = {4'h3, f[7:4]};
                5'd8: cmd_byte = {4'h3, f[3:0]};
                5'd10: cmd_byte = {4'h3, c[`RCP_F_RATE]};
                5'd12: cmd_byte = {4'h3, c[`RCP_F_POWER]};
                5'd14: cmd_byte = {4'h3, c[`RCP_F_BAUD]};
                5'd16: cmd_byte = {4'h3, c[`RCP_F_PARITY]};
                5'd17: cmd_byte = `RCP_CH_CR;
                5'd18: cmd_byte = `RCP_CH_LF;
                default: cmd_byte = `RCP_CH_SP;
            endcase
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Registers and control
reg [2:0] state;
reg [31:0] timer;
reg [31:0] pwr_cnt;
reg [31:0] guard_cnt;
reg [23:0] cfg_freq;
reg [15:0] cfg_codes;
reg [23:0] rpl_freq;
reg [15:0] rpl_codes;
reg is_wr;
reg [4:0] tx_idx;
reg done;
reg timeout;
reg bad_reply;
reg refused;
reg tx_load;
reg [7:0] tx_byte;
wire tx_busy;
wire ready = (pwr_cnt == 32'd0);
wire guard_ok = (guard_cnt == 32'd0);
wire [4:0] last_idx = is_wr ? 5'd18 : 5'd3;
wire start_rd = wr && (addr == `RCP_REG_CTRL) && wdata[`RCP_CTRL_READ];
wire start_wr = wr && (addr == `RCP_REG_CTRL) && wdata[`RCP_CTRL_WRITE] && !wdata[`RCP_CTRL_READ];
wire start_any = start_rd || start_wr;

// Host side refuses fields the module would reject, since it would stay silent
wire fields_ok = (cfg_freq >= `RCP_FREQ_MIN) && (cfg_freq <= `RCP_FREQ_MAX)
    && (cfg_freq[3:0] <= 4'h9) && (cfg_freq[7:4] <= 4'h9) && (cfg_freq[11:8] <= 4'h9)
    && (cfg_freq[15:12] <= 4'h9) && (cfg_freq[19:16] <= 4'h9)
    && (cfg_codes[`RCP_F_RATE] >= 4'h1) && (cfg_codes[`RCP_F_RATE] <= 4'h4)
    && (cfg_codes[`RCP_F_POWER] <= 4'h9)
    && (cfg_codes[`RCP_F_BAUD] <= 4'h6)
    && (cfg_codes[`RCP_F_PARITY] <= 4'h2);
wire can_start = (state == ST_IDLE) && ready && guard_ok && (start_rd || fields_ok);

// Reply parser state
reg rx_vld;
reg [7:0] rx_data;
reg [4:0] p_idx;
reg p_pre_ok;
reg p_chr_ok;
reg [3:0] p_dcnt;
reg [39:0] p_dig;
reg p_end;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        timer <= 32'd0;
        pwr_cnt <= POWERUP_CYC;
        guard_cnt <= 32'd0;
        cfg_freq <= `RCP_RST_FREQ;
        cfg_codes <= `RCP_RST_CODES;
        rpl_freq <= `RCP_RST_FREQ;
        rpl_codes <= `RCP_RST_CODES;
        is_wr <= 1'b0;
        tx_idx <= 5'd0;
        done <= 1'b0;
        timeout <= 1'b0;
        bad_reply <= 1'b0;
        refused <= 1'b0;
        tx_load <= 1'b0;
        tx_byte <= 8'h00;
        cfg_sel_n <= 1'b1;
    end else begin
        tx_load <= 1'b0;
        if (pwr_cnt != 32'd0)
            pwr_cnt <= pwr_cnt - 32'd1;
        if (guard_cnt != 32'd0)
            guard_cnt <= guard_cnt - 32'd1;
        if (timer != 32'd0)
            timer <= timer - 32'd1;
        if (wr && (addr == `RCP_REG_CFG_FREQ) && (state == ST_IDLE))
            cfg_freq <= wdata[23:0];
        if (wr && (addr == `RCP_REG_CFG_CODES) && (state == ST_IDLE))
            cfg_codes <= wdata[15:0];
        if (start_any && !can_start)
            refused <= 1'b1;
        case (state)
            ST_IDLE: begin
                if (start_any && can_start) begin
                    is_wr <= start_wr;
                    done <= 1'b0;
                    timeout <= 1'b0;
                    bad_reply <= 1'b0;
                    refused <= 1'b0;
                    cfg_sel_n <= 1'b0;
                    timer <= ENTRY_CYC;
                    tx_idx <= 5'd0;
                    state <= ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (timer == 32'd0)
                    state <= ST_SEND;
            end
            ST_SEND: begin
                // Only this end talks while the module listens
                if (!tx_busy && !tx_load) begin
                    if (tx_idx > last_idx) begin
                        timer <= REPLY_CYC;
                        state <= ST_WAIT;
                    end else begin
                        tx_byte <= cmd_byte(tx_idx, is_wr, cfg_freq, cfg_codes);
                        tx_load <= 1'b1;
                        tx_idx <= tx_idx + 5'd1;
                    end
                end
            end
            ST_WAIT: begin
                if (p_end) begin
                    if (p_pre_ok && p_chr_ok && (p_dcnt == 4'd10)) begin
                        rpl_freq <= p_dig[39:16];
                        rpl_codes <= {p_dig[3:0], p_dig[7:4], p_dig[11:8], p_dig[15:12]};
                    end else begin
                        bad_reply <= 1'b1;
                    end
                    cfg_sel_n <= 1'b1;
                    timer <= APPLY_CYC;
                    guard_cnt <= RECONF_CYC;
                    state <= ST_APPLY;
                end else if (timer == 32'd0) begin
                    // Silence means the module rejected the command
                    timeout <= 1'b1;
                    cfg_sel_n <= 1'b1;
                    timer <= APPLY_CYC;
                    guard_cnt <= RECONF_CYC;
                    state <= ST_APPLY;
                end
            end
            ST_APPLY: begin
                if (timer == 32'd0) begin
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
            end
            default: begin
                cfg_sel_n <= 1'b1;
                state <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Serial transmitter, 8N1 at the setting rate
reg [8:0] tx_sh;
reg [3:0] tx_bits;
reg [15:0] tx_cnt;
assign tx_busy = (tx_bits != 4'd0);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        tx_sh <= 9'h1FF;
        tx_bits <= 4'd0;
        tx_cnt <= 16'd0;
        uart_tx <= 1'b1;
    end else if (tx_load) begin
        tx_sh <= {1'b1, tx_byte};
        tx_bits <= 4'd10;
        tx_cnt <= BAUD_CYC[15:0] - 16'd1;
        uart_tx <= 1'b0;
    end else if (tx_busy) begin
        if (tx_cnt != 16'd0) begin
            tx_cnt <= tx_cnt - 16'd1;
        end else begin
            tx_cnt <= BAUD_CYC[15:0] - 16'd1;
            tx_bits <= tx_bits - 4'd1;
            if (tx_bits != 4'd1) begin
                uart_tx <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[8:1]};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Serial receiver, samples mid-bit
reg rx_act;
reg [3:0] rx_bits;
reg [15:0] rx_cnt;
reg [7:0] rx_sh;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rx_act <= 1'b0;
        rx_bits <= 4'd0;
        rx_cnt <= 16'd0;
        rx_sh <= 8'h00;
        rx_vld <= 1'b0;
        rx_data <= 8'h00;
    end else begin
        rx_vld <= 1'b0;
        if (!rx_act) begin
            if (!uart_rx) begin
                rx_act <= 1'b1;
                rx_bits <= 4'd9;
                rx_cnt <= BAUD_CYC[16:1];
            end
        end else if (rx_cnt != 16'd0) begin
            rx_cnt <= rx_cnt - 16'd1;
        end else begin
            rx_cnt <= BAUD_CYC[15:0] - 16'd1;
            rx_bits <= rx_bits - 4'd1;
            if (rx_bits == 4'd9) begin
                if (uart_rx)
                    rx_act <= 1'b0;
            end else if (rx_bits != 4'd0) begin
                rx_sh <= {uart_rx, rx_sh[7:1]};
            end else begin
                rx_act <= 1'b0;
                rx_vld <= uart_rx;
                rx_data <= rx_sh;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Reply parser: prefix, then ten digits, CR ignored, LF ends
function [7:0] pre_char;
    input [4:0] i;
    begin
        case (i)
            5'd0: pre_char = 8'h50;
            5'd1: pre_char = 8'h41;
            5'd2: pre_char = 8'h52;
            5'd3: pre_char = 8'h41;
            default: pre_char = `RCP_CH_SP;
        endcase
    end
endfunction

wire rx_digit = (rx_data >= 8'h30) && (rx_data <= 8'h39);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        p_idx <= 5'd0;
        p_pre_ok <= 1'b1;
        p_chr_ok <= 1'b1;
        p_dcnt <= 4'd0;
        p_dig <= 40'h0;
        p_end <= 1'b0;
    end else if (state != ST_WAIT || p_end) begin
        p_idx <= 5'd0;
        p_pre_ok <= 1'b1;
        p_chr_ok <= 1'b1;
        p_dcnt <= 4'd0;
        p_end <= 1'b0;
    end else if (rx_vld) begin
        if (p_idx != 5'd31)
            p_idx <= p_idx + 5'd1;
        if (p_idx < 5'd5) begin
            if (rx_data != pre_char(p_idx))
                p_pre_ok <= 1'b0;
        end else if (rx_digit) begin
            p_dig <= {p_dig[35:0], rx_data[3:0]};
            if (p_dcnt != 4'hF)
                p_dcnt <= p_dcnt + 4'd1;
        end else if (rx_data == `RCP_CH_LF) begin
            p_end <= 1'b1;
        end else if (rx_data != `RCP_CH_SP && rx_data != `RCP_CH_CR) begin
            p_chr_ok <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register reads
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rdata <= 32'h0;
    end else if (rd) begin
        case (addr)
            `RCP_REG_CFG_FREQ: rdata <= {8'h00, cfg_freq};
            `RCP_REG_CFG_CODES: rdata <= {16'h0000, cfg_codes};
            `RCP_REG_STATUS: rdata <= {26'h0, refused, bad_reply, ready, timeout, done, (state != ST_IDLE)};
            `RCP_REG_RPL_FREQ: rdata <= {8'h00, rpl_freq};
            `RCP_REG_RPL_CODES: rdata <= {16'h0000, rpl_codes};
            default: rdata <= 32'h0;
        endcase
    end else begin
        rdata <= 32'h0;
    end
end

endmodule // rcp_host

// *** verification/rcp_host_assertions.sv ***
`timescale 1ns/10ps
`include "rcp_defines.vh"
module rcp_host_assertions #(
    parameter POWERUP_CYC = 50,
    parameter ENTRY_CYC = 20,
    parameter REPLY_CYC = 2000,
    parameter APPLY_CYC = 20,
    parameter RECONF_CYC = 40,
    parameter BAUD_CYC = 8
) (
    input wire clk,
    input wire rstn,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire uart_tx,
    input wire uart_rx,
    input wire cfg_sel_n
);
    // Longest legal low period of the select pin, with some slack for parsing
    localparam int SEL_MAX = ENTRY_CYC + 200 * BAUD_CYC + REPLY_CYC + 64;
    int up_c, lo_c, hi_c, txl_c, txh_c;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_c <= 0;
            lo_c <= 0;
            hi_c <= RECONF_CYC;
            txl_c <= 0;
            txh_c <= BAUD_CYC;
        end else begin
            up_c <= (up_c < POWERUP_CYC) ? up_c + 1 : up_c;
            lo_c <= cfg_sel_n ? 0 : lo_c + 1;
            hi_c <= !cfg_sel_n ? 0 : (hi_c < RECONF_CYC) ? hi_c + 1 : hi_c;
            txl_c <= uart_tx ? 0 : txl_c + 1;
            txh_c <= !uart_tx ? 0 : (txh_c < BAUD_CYC) ? txh_c + 1 : txh_c;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_powerup; !cfg_sel_n |-> up_c >= POWERUP_CYC; endproperty
    a_powerup: assert property (p_powerup) else $error("select before power-up");
    property p_entry; !uart_tx |-> lo_c >= ENTRY_CYC; endproperty
    a_entry: assert property (p_entry) else $error("traffic too soon after select");
    property p_idle; cfg_sel_n |-> uart_tx; endproperty
    a_idle: assert property (p_idle) else $error("traffic while deselected");
    property p_bits; $rose(uart_tx) |-> (txl_c % BAUD_CYC == 0) && (txl_c <= 9 * BAUD_CYC); endproperty
    a_bits: assert property (p_bits) else $error("bad bit time");
    property p_stop; $fell(uart_tx) |-> txh_c >= BAUD_CYC; endproperty
    a_stop: assert property (p_stop) else $error("short stop bit");
    property p_reconf; $fell(cfg_sel_n) |-> hi_c >= RECONF_CYC; endproperty
    a_reconf: assert property (p_reconf) else $error("reselect too soon");
    property p_cause;
        $fell(cfg_sel_n) |-> ($past(wr) && $past(addr) == `RCP_REG_CTRL) ||
            ($past(wr, 2) && $past(addr, 2) == `RCP_REG_CTRL);
    endproperty
    a_cause: assert property (p_cause) else $error("select without command");
    property p_bound; lo_c <= SEL_MAX; endproperty
    a_bound: assert property (p_bound) else $error("select held too long");
    c_cmd: cover property ($fell(cfg_sel_n));
    c_rel: cover property ($rose(cfg_sel_n));
    c_stat: cover property (rd && addr == `RCP_REG_STATUS);
endmodule // rcp_host_assertions
bind rcp_host rcp_host_assertions #(.POWERUP_CYC(POWERUP_CYC), .ENTRY_CYC(ENTRY_CYC), .REPLY_CYC(REPLY_CYC),
    .APPLY_CYC(APPLY_CYC), .RECONF_CYC(RECONF_CYC), .BAUD_CYC(BAUD_CYC)) i_rcp_host_assertions (.clk(clk),
    .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .uart_tx(uart_tx),
    .uart_rx(uart_rx), .cfg_sel_n(cfg_sel_n));

// *** verification/rcp_dev_model.sv ***
`timescale 1ns/10ps
`include "rcp_defines.vh"
module rcp_dev_model #(
    parameter BAUD_CYC = 8,
    parameter ENTRY_CYC = 20,
    parameter POWERUP_CYC = 50
) (
    input wire clk,
    input wire rxd,
    output reg txd,
    input wire set_n,
    input wire [1:0] mode,
    output reg [7:0] viol,
    output reg [23:0] freq,
    output reg [15:0] codes
);
    // Mode 0 prompt, 1 mute, 2 garbled prefix, 3 slow
    reg [7:0] rx_buf [0:31];
    reg [31:0] hdr;
    reg [23:0] nf = `RCP_RST_FREQ, pf;
    reg [15:0] nc = `RCP_RST_CODES, pc;
    reg got_cmd = 1'b0, ok;
    integer n, k, lo_cyc = 0, up_cyc = 0;
    initial begin
        txd = 1'b1;
        viol = 8'h00;
        freq = `RCP_RST_FREQ;
        codes = `RCP_RST_CODES;
    end
    always @(posedge clk) begin
        up_cyc <= up_cyc + 1;
        lo_cyc <= set_n ? 0 : lo_cyc + 1;
    end
    always @(negedge set_n) if (up_cyc < POWERUP_CYC) viol = viol + 8'h01;
    // Host faults are only counted; the bench decides what they mean
    always @(negedge rxd) begin
        if (set_n || got_cmd) viol = viol + 8'h01;
        else if (lo_cyc < ENTRY_CYC) viol = viol + 8'h01;
    end
    ////////////////////////////////////////
    task get_byte(output [7:0] b);
        integer i;
        begin
            @(negedge rxd);
            repeat (BAUD_CYC / 2) @(posedge clk);
            for (i = 0; i < 8; i = i + 1) begin
                repeat (BAUD_CYC) @(posedge clk);
                b[i] = rxd;
            end
            repeat (BAUD_CYC) @(posedge clk);
            if (!rxd) viol = viol + 8'h01;
        end
    endtask
    task put_byte(input [7:0] b);
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                txd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
                repeat (BAUD_CYC) @(posedge clk);
            end
        end
    endtask
    always begin
        @(negedge set_n);
        n = 0;
        while (n == 0 || (n < 31 && rx_buf[n - 1] != `RCP_CH_LF)) begin
            get_byte(rx_buf[n]);
            n = n + 1;
        end
        got_cmd = 1'b1;
        ok = n == 4 && rx_buf[0] == "R" && rx_buf[1] == "D" && rx_buf[2] == `RCP_CH_CR;
        if (n == 19 && rx_buf[0] == "W" && rx_buf[1] == "R") begin
            ok = rx_buf[2] == `RCP_CH_SP && rx_buf[17] == `RCP_CH_CR;
            for (k = 3; k < 17; k = k + 1)
                if (k == 9 || (k > 10 && k[0])) ok = ok && rx_buf[k] == `RCP_CH_SP;
                else ok = ok && rx_buf[k] >= "0" && rx_buf[k] <= "9";
            for (k = 0; k < 6; k = k + 1) pf[23 - 4 * k -: 4] = rx_buf[3 + k][3:0];
            pc = {rx_buf[16][3:0], rx_buf[14][3:0], rx_buf[12][3:0], rx_buf[10][3:0]};
            ok = ok && pf >= `RCP_FREQ_MIN && pf <= `RCP_FREQ_MAX;
            ok = ok && pc[3:0] >= 4'h1 && pc[3:0] <= 4'h4 && pc[11:8] <= 4'h6 && pc[15:12] <= 4'h2;
            if (ok) begin
                nf = pf;
                nc = pc;
            end
        end
        if (ok && mode != 2'd1) begin
            repeat (mode == 2'd3 ? 200 : 4 * BAUD_CYC) @(posedge clk);
            hdr = (mode == 2'd2) ? 32'h50415258 : 32'h50415241;
            for (k = 0; k < 4; k = k + 1) put_byte(hdr[31 - 8 * k -: 8]);
            put_byte(`RCP_CH_SP);
            for (k = 0; k < 6; k = k + 1) put_byte({4'h3, nf[23 - 4 * k -: 4]});
            for (k = 0; k < 8; k = k + 1) put_byte(k[0] ? {4'h3, nc[2 * k + 1 -: 4]} : `RCP_CH_SP);
            put_byte(`RCP_CH_CR);
            put_byte(`RCP_CH_LF);
        end
        @(posedge set_n);
        freq = nf;
        codes = nc;
        got_cmd = 1'b0;
    end
endmodule // rcp_dev_model

// *** verification/rcp_host_tb.sv ***
`timescale 1ns/10ps
`include "rcp_defines.vh"
module rcp_host_tb;
    // Out-of-range settings as {frequency, codes}
    localparam [279:0] BAD = {40'h455001_0393, 40'h417999_0393, 40'h434000_0390, 40'h434000_0395,
        40'h434000_03A3, 40'h434000_0793, 40'h434000_3393};
    // Shortened timing so a whole command fits in a few thousand cycles
    localparam integer PU_CYC = 50, EN_CYC = 20, RP_CYC = 2000, AP_CYC = 20, RC_CYC = 40, BD_CYC = 8;
    reg clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0, v;
    reg [1:0] mode = 2'd0;
    wire [31:0] rdata;
    wire uart_tx, uart_rx, cfg_sel_n;
    wire [7:0] viol;
    wire [23:0] dev_freq;
    wire [15:0] dev_codes;
    integer fails = 0, cmp_count = 0, i;
    rcp_host #(.POWERUP_CYC(PU_CYC), .ENTRY_CYC(EN_CYC), .REPLY_CYC(RP_CYC), .APPLY_CYC(AP_CYC), .RECONF_CYC(RC_CYC),
        .BAUD_CYC(BD_CYC)) i_rcp_host (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .uart_tx(uart_tx), .uart_rx(uart_rx), .cfg_sel_n(cfg_sel_n));
    rcp_dev_model #(.BAUD_CYC(BD_CYC), .ENTRY_CYC(EN_CYC), .POWERUP_CYC(PU_CYC)) i_rcp_dev_model (.clk(clk),
        .rxd(uart_tx),
        .txd(uart_rx), .set_n(cfg_sel_n), .mode(mode), .viol(viol), .freq(dev_freq), .codes(dev_codes));
    always #5 clk = ~clk;
    ////////////////////////////////////////
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("BAD %s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 v = rdata;
        end
    endtask
    task chk_rd(input [7:0] a, input [31:0] exp);
        begin
            rd_reg(a);
            chk($sformatf("reg %h", a), exp, v);
        end
    endtask
    // A refused command must leave the pin high and the block idle
    task refuse(input [31:0] ctrl);
        begin
            wr_reg(`RCP_REG_CTRL, ctrl);
            rd_reg(`RCP_REG_STATUS);
            chk("refused", 32'h20, v & 32'h21);
            chk("select", 32'h1, {31'h0, cfg_sel_n});
        end
    endtask
    task run(input [31:0] ctrl, input [1:0] m, input [31:0] st);
        integer j;
        begin
            mode <= m;
            wr_reg(`RCP_REG_CTRL, ctrl);
            repeat (3) @(posedge clk);
            v = 32'h1;
            for (j = 0; j < 5000 && v[0] !== 1'b0; j = j + 1) rd_reg(`RCP_REG_STATUS);
            chk("status", st, v & 32'h3F);
        end
    endtask
    task report_and_stop;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_rd(`RCP_REG_CFG_FREQ, 32'h434000);
        chk_rd(`RCP_REG_CFG_CODES, 32'h0393);
        chk_rd(`RCP_REG_RPL_CODES, 32'h0393);
        chk_rd(8'h18, 32'h0);
        refuse(32'h1);
        chk("ready", 32'h0, v & 32'h8);
        repeat (60) @(posedge clk);
        run(32'h1, 2'd0, 32'h0A);
        wr_reg(`RCP_REG_CTRL, 32'h1);
        rd_reg(`RCP_REG_STATUS);
        chk("status", 32'h2A, v & 32'h3F);
        chk_rd(`RCP_REG_RPL_FREQ, 32'h434000);
        repeat (50) @(posedge clk);
        for (i = 0; i < 7; i = i + 1) begin
            wr_reg(`RCP_REG_CFG_FREQ, {8'h00, BAD[40 * i + 16 +: 24]});
            wr_reg(`RCP_REG_CFG_CODES, {16'h0, BAD[40 * i +: 16]});
            refuse(32'h2);
        end
        wr_reg(`RCP_REG_CFG_FREQ, 32'h418000);
        wr_reg(`RCP_REG_CFG_CODES, 32'h2604);
        run(32'h2, 2'd0, 32'h0A);
        chk_rd(`RCP_REG_RPL_CODES, 32'h2604);
        chk("dev freq", 32'h418000, {8'h0, dev_freq});
        chk("dev codes", 32'h2604, {16'h0, dev_codes});
        repeat (50) @(posedge clk);
        wr_reg(`RCP_REG_CFG_FREQ, 32'h455000);
        wr_reg(`RCP_REG_CFG_CODES, 32'h1091);
        run(32'h2, 2'd3, 32'h0A);
        chk("dev codes", 32'h1091, {16'h0, dev_codes});
        repeat (50) @(posedge clk);
        run(32'h1, 2'd1, 32'h0E);
        repeat (50) @(posedge clk);
        run(32'h1, 2'd2, 32'h1A);
        chk_rd(`RCP_REG_RPL_FREQ, 32'h455000);
        chk("host faults", 32'h0, {24'h0, viol});
        report_and_stop;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails = fails + 1;
        report_and_stop;
    end
endmodule // rcp_host_tb
